// >>> hdl/intc_pkg.sv
// shared constants and types for the cpu interrupt controller
package intc_pkg;

  // register port geometry
  localparam int AW = 4;
  localparam int DW = 8;

  // register offsets
  localparam logic [AW-1:0] OFF_EDGE_SEL_1  = 4'h0;
  localparam logic [AW-1:0] OFF_EDGE_SEL_2  = 4'h1;
  localparam logic [AW-1:0] OFF_PORT_MODE_1 = 4'h2;
  localparam logic [AW-1:0] OFF_PORT_MODE_5 = 4'h3;
  localparam logic [AW-1:0] OFF_INT_EN_1    = 4'h4;
  localparam logic [AW-1:0] OFF_INT_FLAG_1  = 4'h5;
  localparam logic [AW-1:0] OFF_WAKEUP_FLAG = 4'h6;
  localparam logic [AW-1:0] OFF_PERIPH_FLAG = 4'h7;
  localparam logic [AW-1:0] OFF_PERIPH_EN   = 4'h8;
  localparam logic [AW-1:0] OFF_STATUS      = 4'h9;

  // field positions
  localparam int BIT_A      = 3;  // ext a pin bits
  localparam int BIT_B      = 0;  // ext b pin bits
  localparam int BIT_WKP    = 5;  // wakeup pin bits
  localparam int BIT_DT     = 7;  // direct transfer bits
  localparam int BIT_MASK   = 7;  // interrupt mask bit in ccr
  localparam int BIT_BUSY   = 0;  // status: sequence running
  localparam int BIT_START  = 1;  // status: first instruction done

  // fixed read values of reserved bits
  localparam logic [DW-1:0] FLAG1_ONES  = 8'h30;
  localparam logic [DW-1:0] WKFLAG_ONES = 8'hC0;

  // reset values
  localparam logic [DW-1:0] CCR_RST = 8'h80;

  // sources, in priority order; vector number = index + VEC_BASE
  localparam int NPER = 4;
  localparam int NSRC = 6 + NPER;
  localparam int SRC_NMI = 0;
  localparam int SRC_ABRK = 1;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_EXT_A = 3;
  localparam int SRC_WKP = 4;
  localparam int SRC_DT = 5;
  localparam int SRC_PER = 6;
  localparam logic [7:0] VEC_BASE = 8'h07;

  // exception sequence lengths in states
  localparam logic [1:0] STACK_LAST = 2'h3;  // 4 states
  localparam logic [1:0] VECF_LAST  = 2'h1;  // 2 states
  localparam logic [1:0] FETCH_LAST = 2'h3;  // 4 states
  localparam logic [1:0] PROC_LAST  = 2'h3;  // 4 states
  localparam logic [1:0] PUSH_PC    = 2'h0;
  localparam logic [1:0] PUSH_CCR   = 2'h2;
  localparam logic [15:0] PC_SLOT   = 16'h0002;
  localparam logic [15:0] CCR_SLOT  = 16'h0004;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STACK, ST_VECF, ST_FETCH, ST_PROC
  } seq_state_t;

  typedef struct packed {
    logic nmi_pin;
    logic ext_int_a_pin;
    logic ext_int_b_pin;
    logic wakeup_pin;
  } irq_pins_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } stack_wr_t;

endpackage : intc_pkg

// >>> hdl/cpu_interrupt_controller.sv
// interrupt controller with cpu exception sequencer
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module cpu_interrupt_controller
  import intc_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire irq_pins_t         pins_i,
  input  wire logic              abrk_req_i,
  input  wire logic              dt_req_i,
  input  wire logic [NPER-1:0]   periph_req_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [DW-1:0]     wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DW-1:0]     rdata_o,
  input  wire logic              instr_done_i,
  input  wire logic [15:0]       pc_next_i,
  input  wire logic [15:0]       sp_i,
  input  wire logic              rte_i,
  input  wire logic [DW-1:0]     ccr_restore_i,
  input  wire logic [15:0]       vector_data_i,
  output stack_wr_t              stack_wr_o,
  output logic      [15:0]       sp_new_o,
  output logic                   vec_rd_o,
  output logic      [15:0]       vec_addr_o,
  output logic                   pc_load_o,
  output logic      [15:0]       pc_value_o,
  output logic                   handler_start_o,
  output logic      [DW-1:0]     ccr_o
);

  // set wins over a software write of zero; writing one keeps
  function automatic logic upd_flag(input logic cur, input logic set,
                                    input logic clr_wr, input logic wbit);
    upd_flag = set | (cur & ~(clr_wr & ~wbit));
  endfunction : upd_flag

  // lowest index set wins
  function automatic logic [3:0] prio(input logic [NSRC-1:0] req);
    prio = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        prio = 4'(i);
      end
    end
  endfunction : prio

  // registers
  logic [DW-1:0]   edge_select_reg_1, edge_select_reg_2;
  logic [DW-1:0]   port_mode_reg_1, port_mode_reg_5;
  logic [DW-1:0]   int_enable_reg_1;
  logic [NPER-1:0] periph_en;
  logic            int_flag_a, int_flag_b, dt_flag, wakeup_flag;
  logic [NPER-1:0] periph_flag;
  logic            nmi_pend;
  logic            started;
  logic [DW-1:0]   condition_code_reg;

  // synchronisers and edge history
  irq_pins_t sync1, sync2;
  logic      nmi_prev, a_prev, b_prev, wkp_prev;
  logic      a_gated, b_gated, wkp_gated;
  logic      nmi_edge, a_edge, b_edge, wkp_edge;

  // sequencer
  seq_state_t      state;
  logic [1:0]      cnt;
  logic [3:0]      sel_src;
  logic [15:0]     sp_base;
  logic [NSRC-1:0] raw_req, eff_req;
  logic [3:0]      next_src;
  logic            accept;
  logic            wr_flag1, wr_wkflag, wr_perflag;

  // two flops on every pin before any logic reads it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= pins_i;
      sync2 <= sync1;
    end
  end

  // a pin not given to interrupt input reads as idle high, so a mode
  // change can itself look like an edge
  assign a_gated   = port_mode_reg_1[BIT_A] ? sync2.ext_int_a_pin : 1'b1;
  assign b_gated   = port_mode_reg_1[BIT_B] ? sync2.ext_int_b_pin : 1'b1;
  assign wkp_gated = port_mode_reg_5[BIT_WKP] ? sync2.wakeup_pin : 1'b1;

  // edge history behind the synchronisers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_prev <= 1'b1;
      a_prev   <= 1'b1;
      b_prev   <= 1'b1;
      wkp_prev <= 1'b1;
    end else begin
      nmi_prev <= sync2.nmi_pin;
      a_prev   <= a_gated;
      b_prev   <= b_gated;
      wkp_prev <= wkp_gated;
    end
  end

  // edge select: one picks rising, zero picks falling
  assign nmi_edge = nmi_prev & ~sync2.nmi_pin;
  assign a_edge   = edge_select_reg_1[BIT_A] ? (a_gated & ~a_prev)
                                             : (a_prev & ~a_gated);
  assign b_edge   = edge_select_reg_1[BIT_B] ? (b_gated & ~b_prev)
                                             : (b_prev & ~b_gated);
  assign wkp_edge = edge_select_reg_2[BIT_WKP] ? (wkp_gated & ~wkp_prev)
                                               : (wkp_prev & ~wkp_gated);

  assign wr_flag1   = wr_i && (addr_i == OFF_INT_FLAG_1);
  assign wr_wkflag  = wr_i && (addr_i == OFF_WAKEUP_FLAG);
  assign wr_perflag = wr_i && (addr_i == OFF_PERIPH_FLAG);

  // control registers written by software
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_select_reg_1 <= '0;
      edge_select_reg_2 <= '0;
      port_mode_reg_1   <= '0;
      port_mode_reg_5   <= '0;
      int_enable_reg_1  <= '0;
      periph_en         <= '0;
    end else if (wr_i) begin
      case (addr_i)
        OFF_EDGE_SEL_1:  edge_select_reg_1 <= wdata_i;
        OFF_EDGE_SEL_2:  edge_select_reg_2 <= wdata_i;
        OFF_PORT_MODE_1: port_mode_reg_1   <= wdata_i;
        OFF_PORT_MODE_5: port_mode_reg_5   <= wdata_i;
        OFF_INT_EN_1:    int_enable_reg_1  <= wdata_i;
        OFF_PERIPH_EN:   periph_en         <= wdata_i[NPER-1:0];
        default: ;
      endcase
    end
  end

  // pin and internal request flags, cleared only by writing zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      int_flag_a  <= 1'b0;
      int_flag_b  <= 1'b0;
      dt_flag     <= 1'b0;
      wakeup_flag <= 1'b0;
      periph_flag <= '0;
    end else begin
      int_flag_a  <= upd_flag(int_flag_a, a_edge, wr_flag1, wdata_i[BIT_A]);
      int_flag_b  <= upd_flag(int_flag_b, b_edge, wr_flag1, wdata_i[BIT_B]);
      dt_flag     <= upd_flag(dt_flag, dt_req_i, wr_flag1, wdata_i[BIT_DT]);
      wakeup_flag <= upd_flag(wakeup_flag, wkp_edge, wr_wkflag,
                              wdata_i[BIT_WKP]);
      for (int i = 0; i < NPER; i++) begin
        periph_flag[i] <= upd_flag(periph_flag[i], periph_req_i[i], wr_perflag,
                                   wdata_i[i]);
      end
    end
  end

  // nmi stays pending until the sequencer takes it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (accept && next_src == 4'(SRC_NMI)) begin
      nmi_pend <= 1'b0;
    end
  end

  // the first instruction after reset always runs uninterrupted
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      started <= 1'b0;
    end else if (instr_done_i) begin
      started <= 1'b1;
    end
  end

  // maskable requests gated by flag and enable, then by the mask bit; nmi and break pass ungated
  always_comb begin
    raw_req = '0;
    raw_req[SRC_NMI]   = nmi_pend;
    raw_req[SRC_ABRK]  = abrk_req_i;
    raw_req[SRC_EXT_B] = int_flag_b & int_enable_reg_1[BIT_B];
    raw_req[SRC_EXT_A] = int_flag_a & int_enable_reg_1[BIT_A];
    raw_req[SRC_WKP]   = wakeup_flag & int_enable_reg_1[BIT_WKP];
    raw_req[SRC_DT]    = dt_flag & int_enable_reg_1[BIT_DT];
    for (int i = 0; i < NPER; i++) begin
      raw_req[SRC_PER + i] = periph_flag[i] & periph_en[i];
    end
    eff_req = raw_req;
    for (int i = SRC_EXT_B; i < NSRC; i++) begin
      eff_req[i] = raw_req[i] & ~condition_code_reg[BIT_MASK];
    end
  end

  assign next_src = prio(eff_req);
  assign accept   = (state == ST_IDLE) && instr_done_i && started
                    && (|eff_req);

  // exception sequence: stack, vector fetch, fetch, internal
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt   <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 2'h0;
          if (accept) begin
            state <= ST_STACK;
          end
        end
        ST_STACK: begin
          cnt <= (cnt == STACK_LAST) ? 2'h0 : cnt + 2'h1;
          if (cnt == STACK_LAST) begin
            state <= ST_VECF;
          end
        end
        ST_VECF: begin
          cnt <= (cnt == VECF_LAST) ? 2'h0 : cnt + 2'h1;
          if (cnt == VECF_LAST) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          cnt <= (cnt == FETCH_LAST) ? 2'h0 : cnt + 2'h1;
          if (cnt == FETCH_LAST) begin
            state <= ST_PROC;
          end
        end
        ST_PROC: begin
          cnt <= (cnt == PROC_LAST) ? 2'h0 : cnt + 2'h1;
          if (cnt == PROC_LAST) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= 2'h0;
        end
      endcase
    end
  end

  // latch the winning source and stack base at acceptance
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_src    <= 4'h0;
      sp_base    <= 16'h0000;
      vec_addr_o <= 16'h0000;
    end else if (accept) begin
      sel_src    <= next_src;
      sp_base    <= sp_i & 16'hFFFE;
      vec_addr_o <= {7'h00, (VEC_BASE + {4'h0, next_src}), 1'b0};
    end
  end

  // stack pushes: pc of next instruction, then ccr, words only
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_wr_o <= '0;
      sp_new_o   <= 16'h0000;
    end else begin
      stack_wr_o.we <= 1'b0;
      if (state == ST_STACK && cnt == PUSH_PC) begin
        stack_wr_o.we   <= 1'b1;
        stack_wr_o.addr <= (sp_base - PC_SLOT) & 16'hFFFE;
        stack_wr_o.data <= pc_next_i;
      end else if (state == ST_STACK && cnt == PUSH_CCR) begin
        stack_wr_o.we   <= 1'b1;
        stack_wr_o.addr <= (sp_base - CCR_SLOT) & 16'hFFFE;
        stack_wr_o.data <= {condition_code_reg, condition_code_reg};
        sp_new_o        <= sp_base - CCR_SLOT;
      end
    end
  end

  // condition codes: mask set after stacking, restored on return
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      condition_code_reg <= CCR_RST;
    end else if (state == ST_STACK && cnt == STACK_LAST) begin
      condition_code_reg[BIT_MASK] <= 1'b1;
    end else if (rte_i && state == ST_IDLE) begin
      condition_code_reg <= ccr_restore_i;
    end
  end

  assign ccr_o    = condition_code_reg;
  assign vec_rd_o = (state == ST_VECF);

  // start address taken from the vector, loaded into pc
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_value_o      <= 16'h0000;
      pc_load_o       <= 1'b0;
      handler_start_o <= 1'b0;
    end else begin
      pc_load_o       <= (state == ST_VECF) && (cnt == VECF_LAST);
      handler_start_o <= (state == ST_PROC) && (cnt == PROC_LAST);
      if (state == ST_VECF && cnt == VECF_LAST) begin
        pc_value_o <= vector_data_i & 16'hFFFE;
      end
    end
  end

  // read data stands the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFF_EDGE_SEL_1:  rdata_o <= edge_select_reg_1;
        OFF_EDGE_SEL_2:  rdata_o <= edge_select_reg_2;
        OFF_PORT_MODE_1: rdata_o <= port_mode_reg_1;
        OFF_PORT_MODE_5: rdata_o <= port_mode_reg_5;
        OFF_INT_EN_1:    rdata_o <= int_enable_reg_1;
        OFF_INT_FLAG_1:  rdata_o <= FLAG1_ONES | {dt_flag, 3'h0, int_flag_a, 2'h0, int_flag_b};
        OFF_WAKEUP_FLAG: rdata_o <= WKFLAG_ONES | {2'h0, wakeup_flag, 5'h00};
        OFF_PERIPH_FLAG: rdata_o <= {4'h0, periph_flag};
        OFF_PERIPH_EN:   rdata_o <= {4'h0, periph_en};
        OFF_STATUS:      rdata_o <= {condition_code_reg[BIT_MASK], 5'h00, started, state != ST_IDLE};
        default:         rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_stacking;
    (state == ST_STACK) [*4];
  endsequence
  sequence s_vector;
    (state == ST_VECF) [*2];
  endsequence
  a_nmi_edge_pend: assert property (nmi_edge |=> nmi_pend)
    else $error("nmi edge not latched");
  a_nmi_first_vec: assert property (accept && nmi_pend |=> sel_src == 4'h0)
    else $error("nmi not given first place");
  a_flag_set_wins: assert property (
    a_edge && wr_flag1 && !wdata_i[BIT_A] |=> int_flag_a)
    else $error("flag lost to clear");
  a_write_one_keeps: assert property (wr_flag1 && wdata_i[BIT_A] && !a_edge
                                      |=> int_flag_a == $past(int_flag_a))
    else $error("writing one altered flag");
  a_masked_holds: assert property (
    condition_code_reg[BIT_MASK] && !nmi_pend && !abrk_req_i |-> !accept)
    else $error("masked request accepted");
  a_no_early_accept: assert property (!started |-> !accept)
    else $error("accepted before first instruction");
  a_seq_steps: assert property (
    accept |=> s_stacking ##1 s_vector ##1 (state == ST_FETCH))
    else $error("exception step length wrong");
  a_mask_after_stack: assert property (accept |-> ##5 condition_code_reg[BIT_MASK])
    else $error("mask not set after stacking");
  a_handler_time: assert property (accept |-> ##15 handler_start_o)
    else $error("handler start late or early");
  a_stack_even: assert property (stack_wr_o.we |-> !stack_wr_o.addr[0])
    else $error("odd stack address");

endmodule : cpu_interrupt_controller

// >>> verification/cpu_model.sv
// behavioural cpu core that faces the interrupt controller
`timescale 1ns/1ps
module cpu_model
  import intc_pkg::*;
#(
  parameter logic [15:0] SP_VAL = 16'h0FF1,
  parameter logic [15:0] PC_VAL = 16'h1234
)(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        vec_rd_i,
  input  wire logic [15:0] vec_addr_i,
  output logic             instr_done_o,
  output logic      [15:0] pc_next_o,
  output logic      [15:0] sp_o,
  output logic      [15:0] vector_data_o
);
  logic [1:0]  cnt;
  logic [15:0] word;

  // one instruction completes every third cycle while running
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt          <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      cnt          <= (run_i && cnt != 2'h2) ? cnt + 2'h1 : 2'h0;
      instr_done_o <= run_i && cnt == 2'h2;
    end
  end

  // odd stack pointer and odd vector word probe the word alignment
  assign pc_next_o     = PC_VAL;
  assign sp_o          = SP_VAL;
  assign word          = {8'hA5, vec_addr_i[7:0] | 8'h01};
  assign vector_data_o = vec_rd_i ? word : ~word;
endmodule : cpu_model

// >>> verification/tb_top.sv
// self-checking testbench for the cpu interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top
  import intc_pkg::*;
;
  localparam logic [15:0] SP_VAL = 16'h0FF1;
  localparam logic [15:0] PC_VAL = 16'h1234;
  logic              mclk_i, rst_i, abrk_req_i, dt_req_i, wr_i, rd_i, rte_i, run;
  logic              instr_done, vec_rd_o, pc_load_o, handler_start_o;
  irq_pins_t         pins_i;
  logic [NPER-1:0]   periph_req_i;
  logic [AW-1:0]     addr_i;
  logic [DW-1:0]     wdata_i, rdata_o, ccr_restore_i, ccr_o, ccr_now;
  logic [15:0]       pc_next, sp, vec_data, sp_new_o, vec_addr_o, pc_value_o;
  stack_wr_t         stack_wr_o;
  int                n_fail, n_tests;

  cpu_interrupt_controller uut (.mclk_i(mclk_i), .rst_i(rst_i), .pins_i(pins_i),
    .abrk_req_i(abrk_req_i), .dt_req_i(dt_req_i), .periph_req_i(periph_req_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .instr_done_i(instr_done), .pc_next_i(pc_next), .sp_i(sp), .rte_i(rte_i),
    .ccr_restore_i(ccr_restore_i), .vector_data_i(vec_data), .stack_wr_o(stack_wr_o),
    .sp_new_o(sp_new_o), .vec_rd_o(vec_rd_o), .vec_addr_o(vec_addr_o),
    .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .handler_start_o(handler_start_o),
    .ccr_o(ccr_o));

  cpu_model #(.SP_VAL(SP_VAL), .PC_VAL(PC_VAL)) cpu (.mclk_i(mclk_i), .rst_i(rst_i),
    .run_i(run), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o), .instr_done_o(instr_done),
    .pc_next_o(pc_next), .sp_o(sp), .vector_data_o(vec_data));

  // 200 mhz clock
  always #2.5 mclk_i = ~mclk_i;

  task automatic results;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk_i) begin addr_i <= a; rd_i <= 1'b1; end
    @(posedge mclk_i) rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, exp)
  endtask : rd

  // return from interrupt with a chosen condition code
  task automatic rte(input logic [DW-1:0] c);
    @(posedge mclk_i) begin rte_i <= 1'b1; ccr_restore_i <= c; end
    @(posedge mclk_i) rte_i <= 1'b0;
    #1;
    ccr_now = c;
    `CHK(ccr_o, c)
  endtask : rte

  // low pulse on the selected pins
  task automatic pulse(input logic [3:0] m);
    @(posedge mclk_i) pins_i <= irq_pins_t'(pins_i & ~m);
    repeat (4) @(posedge mclk_i);
    pins_i <= irq_pins_t'(pins_i | m);
    repeat (6) @(posedge mclk_i);
  endtask : pulse

  // no acceptance may start for n cycles
  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      if (stack_wr_o.we !== 1'b0 || vec_rd_o !== 1'b0) hits++;
    end
    `CHK(hits, 0)
  endtask : quiet

  // follow one whole acceptance from the first push to the handler
  task automatic accept(input logic [15:0] vec, input logic drop);
    int          k;
    logic [15:0] base;
    k    = 0;
    base = SP_VAL & 16'hFFFE;
    while (stack_wr_o.we !== 1'b1 && k < 100) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k >= 100) begin
      n_fail++;
      results();
    end
    `CHK(stack_wr_o.addr, base - 16'h0002)
    `CHK(stack_wr_o.data, PC_VAL)
    @(posedge mclk_i) if (drop) abrk_req_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK({stack_wr_o.we, stack_wr_o.addr}, {1'b1, base - 16'h0004})
    `CHK(stack_wr_o.data, {ccr_now, ccr_now})
    `CHK(sp_new_o, base - 16'h0004)
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK({ccr_o[BIT_MASK], vec_rd_o}, 2'h3)
    `CHK(vec_addr_o, vec)
    @(posedge mclk_i);
    #1;
    `CHK({pc_load_o, pc_value_o}, {1'b1, 8'hA5, vec[7:0]})
    repeat (8) @(posedge mclk_i);
    #1;
    `CHK(handler_start_o, 1'b1)
    ccr_now = ccr_now | 8'h80;
  endtask : accept

  initial begin
    mclk_i = 1'b0; rst_i = 1'b1; run = 1'b0; abrk_req_i = 1'b0; dt_req_i = 1'b0;
    wr_i = 1'b0; rd_i = 1'b0; rte_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00;
    ccr_restore_i = 8'h00; periph_req_i = 4'h0; pins_i = irq_pins_t'(4'hF);
    n_fail = 0; n_tests = 0; ccr_now = 8'h80;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped read
    rd(OFF_INT_FLAG_1, 8'h30);
    rd(OFF_WAKEUP_FLAG, 8'hC0);
    rd(OFF_STATUS, 8'h80);
    rd(4'hF, 8'h00);
    // nmi and break wait for the first instruction, nmi wins
    @(posedge mclk_i) begin pins_i.nmi_pin <= 1'b0; abrk_req_i <= 1'b1; end
    quiet(20);
    @(posedge mclk_i) run <= 1'b1;
    accept(16'h000E, 1'b0);
    @(posedge mclk_i) pins_i.nmi_pin <= 1'b1;
    accept(16'h0010, 1'b1);
    // both external pins on rising edges, held while masked
    wr(OFF_EDGE_SEL_1, 8'h09);
    rd(OFF_EDGE_SEL_1, 8'h09);
    wr(OFF_PORT_MODE_1, 8'h09);
    wr(OFF_INT_EN_1, 8'h09);
    pulse(4'h6);
    rd(OFF_INT_FLAG_1, 8'h39);
    quiet(20);
    rte(8'h00);
    accept(16'h0012, 1'b0);
    wr(OFF_INT_FLAG_1, 8'h08);
    rd(OFF_INT_FLAG_1, 8'h38);
    rte(8'h00);
    accept(16'h0014, 1'b0);
    wr(OFF_INT_FLAG_1, 8'h00);
    rd(OFF_INT_FLAG_1, 8'h30);
    // disabled pin request stays away from the cpu
    wr(OFF_INT_EN_1, 8'h00);
    pulse(4'h4);
    rd(OFF_INT_FLAG_1, 8'h38);
    rte(8'h00);
    quiet(30);
    wr(OFF_INT_EN_1, 8'h08);
    accept(16'h0014, 1'b0);
    wr(OFF_INT_FLAG_1, 8'h00);
    wr(OFF_INT_EN_1, 8'h00);
    // wakeup pin on a falling edge
    wr(OFF_EDGE_SEL_2, 8'h00);
    wr(OFF_PORT_MODE_5, 8'h20);
    pulse(4'h1);
    rd(OFF_WAKEUP_FLAG, 8'hE0);
    rte(8'h00);
    quiet(30);
    wr(OFF_INT_EN_1, 8'h20);
    accept(16'h0016, 1'b0);
    wr(OFF_WAKEUP_FLAG, 8'h00);
    rd(OFF_WAKEUP_FLAG, 8'hC0);
    // wakeup pin on a rising edge, held while masked
    wr(OFF_EDGE_SEL_2, 8'h20);
    pulse(4'h1);
    rd(OFF_WAKEUP_FLAG, 8'hE0);
    wr(OFF_WAKEUP_FLAG, 8'h00);
    // direct transfer and peripheral events together
    @(posedge mclk_i) begin dt_req_i <= 1'b1; periph_req_i <= 4'h4; end
    @(posedge mclk_i) begin dt_req_i <= 1'b0; periph_req_i <= 4'h0; end
    rd(OFF_INT_FLAG_1, 8'hB0);
    rd(OFF_PERIPH_FLAG, 8'h04);
    wr(OFF_INT_EN_1, 8'h80);
    wr(OFF_PERIPH_EN, 8'h04);
    rte(8'h00);
    accept(16'h0018, 1'b0);
    wr(OFF_INT_FLAG_1, 8'h00);
    rte(8'h00);
    accept(16'h001E, 1'b0);
    wr(OFF_PERIPH_FLAG, 8'h00);
    rd(OFF_PERIPH_FLAG, 8'h00);
    // switch of a pin into interrupt mode while held low sets its flag
    wr(OFF_INT_EN_1, 8'h00);
    wr(OFF_EDGE_SEL_1, 8'h00);
    wr(OFF_PORT_MODE_1, 8'h00);
    pins_i.ext_int_a_pin <= 1'b0;
    wr(OFF_PORT_MODE_1, 8'h08);
    rd(OFF_INT_FLAG_1, 8'h38);
    rd(OFF_STATUS, 8'h82);
    wr(OFF_INT_FLAG_1, 8'h00);
    rd(OFF_INT_FLAG_1, 8'h30);
    results();
  end
endmodule : tb_top
